// ---- bst_port.sv ----
// boundary-scan test port top: pin sampling, registers, output
// assumes test pins are asynchronous to the core clock and that
// the test clock is much slower than the core clock
`timescale 1ns/1ps
`default_nettype none
module bst_port
	import bst_pkg::*;
(
	input  wire logic               i_core_clk,   // core clock
	input  wire logic               i_reset,      // synchronous reset
	input  wire logic               i_tck,        // test clock pin
	input  wire logic               i_tms,        // mode select pin
	input  wire logic               i_tdi,        // test data in pin
	input  wire logic               i_trst_n,     // test reset pin
	input  wire logic [BSR_LEN-1:0] i_pin_val,    // levels seen at pins
	input  wire logic [BSR_LEN-1:0] i_core_val,   // functional values
	output logic                    o_tdo,        // test data out
	output logic                    o_tdo_oe,     // tdo driver enable
	output logic [BSR_LEN-1:0]      o_cell_val    // values toward pins
);
	// ============================================================
	// pin synchronisers
	logic [3:0]         sa_r;      // first stage: tck tms tdi trst_n
	logic [3:0]         sb_r;      // second stage
	logic               tck_d_r;   // delayed tck for edge finding
	logic [BSR_LEN-1:0] pa_r;      // pin values first stage
	logic [BSR_LEN-1:0] pb_r;      // pin values second stage
	logic               rise;      // test clock rise pulse
	logic               fall;      // test clock fall pulse
	logic               tms_s;     // synchronised mode select
	logic               tdi_s;     // synchronised data in
	logic               trst_s;    // synchronised reset, high active

	// two flops on every outside level; reset loads the idle pin levels
	// (tck low, pulled-up pins high) and the edge flop matches the tck
	// stage, so no false rise steps the controller after reset
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			sa_r    <= 4'h7;  // tck tms tdi trst_n = 0 1 1 1
			sb_r    <= 4'h7;
			tck_d_r <= 1'b0;
		end else begin
			sa_r    <= {i_tck, i_tms, i_tdi, i_trst_n};
			sb_r    <= sa_r;
			tck_d_r <= sb_r[3];
		end
	end

	// pin capture path, no reset needed on pure data
	always_ff @(posedge i_core_clk) begin
		pa_r <= i_pin_val;
		pb_r <= pa_r;
	end

	// edge pulses act as the test clock enable
	always_comb begin
		rise   = sb_r[3] & ~tck_d_r;
		fall   = ~sb_r[3] & tck_d_r;
		tms_s  = sb_r[2];
		tdi_s  = sb_r[1];
		trst_s = ~sb_r[0];
	end

	// ============================================================
	// controller
	bst_tap_if tap ();
	bst_state_t st;  // controller state

	assign tap.step = rise;
	assign tap.tms  = tms_s;
	assign tap.trst = trst_s;
	assign st       = tap.state;

	bst_tap_fsm u_fsm (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.tap        (tap.ctrl)
	);

	// ============================================================
	// instruction register
	logic [IR_LEN-1:0] ir_sh_r;   // shift stage
	logic [IR_LEN-1:0] ir_sh_nxt;
	logic [IR_LEN-1:0] ir_r;      // current instruction
	logic [IR_LEN-1:0] ir_nxt;

	// capture, shift and update of the instruction
	always_comb begin
		ir_sh_nxt = ir_sh_r;
		ir_nxt    = ir_r;
		if (trst_s || (rise && st == ST_TLR)) begin
			ir_nxt = IR_RSTVAL;
		end else begin
			if (rise && st == ST_CIR) begin
				ir_sh_nxt = IR_CAPVAL;
			end
			if (rise && st == ST_SHIR) begin
				ir_sh_nxt = {tdi_s, ir_sh_r[IR_LEN-1:1]};
			end
			if (fall && st == ST_UIR) begin
				ir_nxt = ir_sh_r;
			end
		end
	end

	// register only
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ir_sh_r <= IR_CAPVAL;
			ir_r    <= IR_RSTVAL;
		end else begin
			ir_sh_r <= ir_sh_nxt;
			ir_r    <= ir_nxt;
		end
	end

	// ============================================================
	// data registers
	logic               sel_bsr;     // chain selected by decode
	logic               extest;      // external test active
	logic               byp_r;       // bypass stage
	logic               byp_nxt;
	logic [BSR_LEN-1:0] bsr_sh_r;    // chain shift stages
	logic [BSR_LEN-1:0] bsr_sh_nxt;
	logic [BSR_LEN-1:0] bsr_up_r;    // chain update stages
	logic [BSR_LEN-1:0] bsr_up_nxt;

	// decode of current instruction
	always_comb begin
		sel_bsr = bst_sel_bsr(ir_r);
		extest  = (ir_r == IR_EXTEST);
	end

	// capture, shift and update of the selected register
	always_comb begin
		byp_nxt    = byp_r;
		bsr_sh_nxt = bsr_sh_r;
		bsr_up_nxt = bsr_up_r;
		if (rise && st == ST_CDR) begin
			if (sel_bsr) begin
				bsr_sh_nxt = pb_r;
			end else begin
				byp_nxt = 1'b0;
			end
		end
		if (rise && st == ST_SHDR) begin
			if (sel_bsr) begin
				bsr_sh_nxt = {tdi_s, bsr_sh_r[BSR_LEN-1:1]};
			end else begin
				byp_nxt = tdi_s;
			end
		end
		if (fall && st == ST_UDR && sel_bsr) begin
			bsr_up_nxt = bsr_sh_r;
		end
	end

	// register only
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			byp_r    <= 1'b0;
			bsr_sh_r <= '0;
			bsr_up_r <= '0;
		end else begin
			byp_r    <= byp_nxt;
			bsr_sh_r <= bsr_sh_nxt;
			bsr_up_r <= bsr_up_nxt;
		end
	end

	// ============================================================
	// serial output and pin drive
	logic               tdo_nxt;
	logic               tdo_oe_nxt;
	logic [BSR_LEN-1:0] cell_nxt;

	// output changes only on test clock fall, except the driver enable, which test reset turns off at once
	always_comb begin
		tdo_nxt    = o_tdo;
		tdo_oe_nxt = o_tdo_oe;
		if (trst_s) begin
			tdo_oe_nxt = 1'b0;
		end else if (fall) begin
			unique case (st)
				ST_SHIR: begin
					tdo_nxt    = ir_sh_r[0];
					tdo_oe_nxt = 1'b1;
				end
				ST_SHDR: begin
					tdo_nxt    = sel_bsr ? bsr_sh_r[0] : byp_r;
					tdo_oe_nxt = 1'b1;
				end
				default: begin
					tdo_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	// update stages reach pins only in external test; a one in a
	// control cell passes unchanged, so it enables its driver
	always_comb begin
		cell_nxt = extest ? bsr_up_r : i_core_val;
	end

	// register only
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_tdo      <= 1'b0;
			o_tdo_oe   <= 1'b0;
			o_cell_val <= '0;
		end else begin
			o_tdo      <= tdo_nxt;
			o_tdo_oe   <= tdo_oe_nxt;
			o_cell_val <= cell_nxt;
		end
	end

	// ============================================================
	// checks
	sequence s_fall_shdr;
		fall && !trst_s && st == ST_SHDR;
	endsequence
	sequence s_fall_idle;
		fall && !trst_s && st != ST_SHDR && st != ST_SHIR;
	endsequence

	a_tdo_hiz_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_fall_idle |=> !o_tdo_oe)
		else $error("tdo driven outside shifting");
	a_tdo_lsb_first: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(s_fall_shdr and sel_bsr) |=> o_tdo_oe && o_tdo == $past(bsr_sh_r[0]))
		else $error("chain cell 0 not first on tdo");
	a_tdo_fall_only: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(!fall && !trst_s) |=> $stable(o_tdo))
		else $error("tdo changed away from a fall");
	a_ir_shift_in: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(rise && !trst_s && st == ST_SHIR) |=> ir_sh_r == {$past(tdi_s), $past(ir_sh_r[1])})
		else $error("instruction shift wrong");
	a_bypass_one: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(rise && st == ST_SHDR && !sel_bsr) |=> byp_r == $past(tdi_s))
		else $error("bypass stage did not take tdi");
	a_bsr_shift_in: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(rise && st == ST_SHDR && sel_bsr) |=> bsr_sh_r[BSR_LEN-1] == $past(tdi_s)
		&& bsr_sh_r[BSR_LEN-2:0] == $past(bsr_sh_r[BSR_LEN-1:1]))
		else $error("chain shift wrong");
	a_decode_bsr: assert property (@(posedge i_core_clk) disable iff (i_reset)
		sel_bsr == (ir_r != 2'h3) && extest == (ir_r == 2'h0))
		else $error("instruction decode wrong");
	a_extest_drive: assert property (@(posedge i_core_clk) disable iff (i_reset)
		##1 o_cell_val == ($past(extest) ? $past(bsr_up_r) : $past(i_core_val)))
		else $error("pin drive source wrong");
	a_trst_ir: assert property (@(posedge i_core_clk) disable iff (i_reset)
		trst_s |=> ir_r == IR_BYPASS && !o_tdo_oe)
		else $error("test reset left instruction or tdo");

	// ============================================================
	// checks of the capture, update and output steps
	// one-cycle pulses that start each step
	sequence s_rise_cir;
		rise && !trst_s && st == ST_CIR;
	endsequence
	sequence s_rise_cdr;
		rise && st == ST_CDR;
	endsequence
	sequence s_fall_uir;
		fall && !trst_s && st == ST_UIR;
	endsequence
	sequence s_fall_udr;
		fall && st == ST_UDR;
	endsequence
	sequence s_fall_shir;
		fall && !trst_s && st == ST_SHIR;
	endsequence

	// instruction path: capture value, update copy, hold between updates
	a_ir_capture: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_rise_cir |=> ir_sh_r == IR_CAPVAL)
		else $error("instruction capture value wrong");
	a_ir_update: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_fall_uir |=> ir_r == $past(ir_sh_r))
		else $error("instruction update wrong");
	a_ir_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(!fall && !trst_s && !(rise && st == ST_TLR)) |=> $stable(ir_r))
		else $error("instruction changed outside update");

	// data path: capture source and chain update stage
	a_dr_capture: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_rise_cdr |=> ($past(sel_bsr) ? bsr_sh_r == $past(pb_r) : !byp_r))
		else $error("data capture wrong");
	a_bsr_update: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_fall_udr |=> bsr_up_r == $past(bsr_sh_r) || !$past(sel_bsr))
		else $error("chain update stage wrong");
	a_bsr_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!(fall && st == ST_UDR) |=> $stable(bsr_up_r))
		else $error("chain update stage moved outside update");

	// serial output: lowest stage of the selected path after each fall in a shift state
	a_tdo_ir_lsb: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_fall_shir |=> o_tdo_oe && o_tdo == $past(ir_sh_r[0]))
		else $error("instruction bit 0 not on tdo");
	a_tdo_bypass: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(fall && !trst_s && st == ST_SHDR && !sel_bsr) |=> o_tdo == $past(byp_r))
		else $error("bypass stage not on tdo");
endmodule : bst_port
`default_nettype wire

// ---- bst_pkg.sv ----
// constants, types and helpers of the boundary-scan test port
// assumes one core clock; the test clock arrives as a sampled pin
// Function
// - sample mode select on test clock rise
// - capture test data input on rise
// - route input bits to instruction or data
// - update test data output on fall
// - output shows selected register, one bit per clock
// - output driver high impedance unless shifting
// - test reset clears controller and instruction
// - scan logic never disturbs normal switching
// - two-bit instruction shifted in shift state, loaded in update state
// - decode 11 bypass, 10/01 sample, 00 extest
// - bypass is one flip-flop stage
// - boundary chain holds exactly 118 cells
// - cell 0 leaves first on output
// - control cell one enables its driver
package bst_pkg;
	// ============================================================
	// chain and instruction layout
	localparam int        BSR_LEN    = 118;     // cells in chain
	localparam int        IR_LEN     = 2;       // instruction width
	localparam logic [1:0] IR_BYPASS = 2'h3;    // bypass code
	localparam logic [1:0] IR_SAMP_A = 2'h2;    // sample code
	localparam logic [1:0] IR_SAMP_B = 2'h1;    // sample code
	localparam logic [1:0] IR_EXTEST = 2'h0;    // external test code
	localparam logic [1:0] IR_CAPVAL = 2'h1;    // captured on capture-ir
	localparam logic [1:0] IR_RSTVAL = IR_BYPASS; // held after reset

	// ============================================================
	// controller states
	typedef enum logic [3:0] {
		ST_TLR  = 4'h0,
		ST_RTI  = 4'h1,
		ST_SDR  = 4'h2,
		ST_CDR  = 4'h3,
		ST_SHDR = 4'h4,
		ST_E1DR = 4'h5,
		ST_PDR  = 4'h6,
		ST_E2DR = 4'h7,
		ST_UDR  = 4'h8,
		ST_SIR  = 4'h9,
		ST_CIR  = 4'hA,
		ST_SHIR = 4'hB,
		ST_E1IR = 4'hC,
		ST_PIR  = 4'hD,
		ST_E2IR = 4'hE,
		ST_UIR  = 4'hF
	} bst_state_t;

	// boundary chain selected for every code but bypass
	function automatic logic bst_sel_bsr(input logic [1:0] ir);
		return ir != IR_BYPASS;
	endfunction : bst_sel_bsr
endpackage : bst_pkg

// ---- bst_tap_if.sv ----
// carrier between the port top and its controller
// assumes both ends run on the core clock
`timescale 1ns/1ps
`default_nettype none
interface bst_tap_if;
	import bst_pkg::*;
	logic       step;     // one-cycle pulse per test clock rise
	logic       tms;      // synchronised mode select
	logic       trst;     // synchronised test reset, active high
	bst_state_t state;    // current controller state
	modport ctrl (input step, input tms, input trst, output state);
	modport user (output step, output tms, output trst, input state);
endinterface : bst_tap_if
`default_nettype wire

// ---- bst_tap_fsm.sv ----
// sixteen-state test access port controller
// assumes step pulses once per test clock rise, on the core clock
`timescale 1ns/1ps
`default_nettype none
module bst_tap_fsm
	import bst_pkg::*;
(
	input  wire logic i_core_clk,  // core clock
	input  wire logic i_reset,     // synchronous reset
	bst_tap_if.ctrl   tap          // step, mode and state
);
	// ============================================================
	// state register
	bst_state_t st_r;    // current state
	bst_state_t st_nxt;  // next state

	// next state from sampled mode select
	always_comb begin
		st_nxt = st_r;
		if (tap.trst) begin
			st_nxt = ST_TLR;
		end else if (tap.step) begin
			unique case (st_r)
				ST_TLR:  st_nxt = tap.tms ? ST_TLR  : ST_RTI;
				ST_RTI:  st_nxt = tap.tms ? ST_SDR  : ST_RTI;
				ST_SDR:  st_nxt = tap.tms ? ST_SIR  : ST_CDR;
				ST_CDR:  st_nxt = tap.tms ? ST_E1DR : ST_SHDR;
				ST_SHDR: st_nxt = tap.tms ? ST_E1DR : ST_SHDR;
				ST_E1DR: st_nxt = tap.tms ? ST_UDR  : ST_PDR;
				ST_PDR:  st_nxt = tap.tms ? ST_E2DR : ST_PDR;
				ST_E2DR: st_nxt = tap.tms ? ST_UDR  : ST_SHDR;
				ST_UDR:  st_nxt = tap.tms ? ST_SDR  : ST_RTI;
				ST_SIR:  st_nxt = tap.tms ? ST_TLR  : ST_CIR;
				ST_CIR:  st_nxt = tap.tms ? ST_E1IR : ST_SHIR;
				ST_SHIR: st_nxt = tap.tms ? ST_E1IR : ST_SHIR;
				ST_E1IR: st_nxt = tap.tms ? ST_UIR  : ST_PIR;
				ST_PIR:  st_nxt = tap.tms ? ST_E2IR : ST_PIR;
				ST_E2IR: st_nxt = tap.tms ? ST_UIR  : ST_SHIR;
				ST_UIR:  st_nxt = tap.tms ? ST_SDR  : ST_RTI;
			endcase
		end
	end

	// register only
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_r <= ST_TLR;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tap.state = st_r;

	// ============================================================
	// checks
	a_trst_to_reset: assert property (@(posedge i_core_clk) disable iff (i_reset)
		tap.trst |=> st_r == ST_TLR)
		else $error("test reset did not force reset state");
	a_tms_hold_reset: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(tap.step && !tap.trst && st_r == ST_TLR && tap.tms) |=> st_r == ST_TLR)
		else $error("reset state left with mode select high");
	a_tms_no_step: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(!tap.step && !tap.trst) |=> st_r == $past(st_r))
		else $error("state moved without a test clock rise");
endmodule : bst_tap_fsm
`default_nettype wire

// ---- bst_jtag_master.sv ----
// scan master model: drives the test pins of the boundary-scan port
// assumes the core clock only paces its pin changes, 48 ns test clock
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_master (
	input  wire logic i_clk,     // core clock, pacing only
	input  wire logic i_tdo,     // serial data from the port
	input  wire logic i_tdo_oe,  // port driver enable
	output logic      o_tck,     // test clock, still between frames
	output logic      o_tms,     // mode select
	output logic      o_tdi,     // test data in
	output logic      o_trst_n   // test reset, active low
);
	// ============================================================
	// idle levels: pulled-up pins high, clock parked low
	initial begin
		o_tck    = 1'b0;
		o_tms    = 1'b1;
		o_tdi    = 1'b1;
		o_trst_n = 1'b1;
	end

	// ============================================================
	// half a test clock period: six core cycles, off the edge
	task automatic half();
		repeat (6) @(posedge i_clk);
		#1;
	endtask : half

	// one test clock period; port output taken at the rise
	task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
		o_tms = tms;      // mode chosen while clock is low
		o_tdi = tdi;
		half();
		o_tck = 1'b1;     // port samples on this rise
		tdo   = i_tdo;    // master reads on the rise
		oe    = i_tdo_oe;
		half();
		o_tck = 1'b0;     // port updates its output on this fall
	endtask : tick

	// test reset pulse, long enough for the synchroniser
	task automatic pulse_trst();
		o_trst_n = 1'b0;
		repeat (8) @(posedge i_clk);
		#1;
		o_trst_n = 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
	endtask : pulse_trst
endmodule : bst_jtag_master
`default_nettype wire

// ---- bst_port_tb.sv ----
// self-checking bench of the boundary-scan test port
// assumes the scan master model drives every test pin
`timescale 1ns/1ps
`default_nettype none
module bst_port_tb;
	import bst_pkg::*;
	logic               clk, rst, tck, tms, tdi, trst_n; // clock, reset, pins
	logic               tdo, tdo_oe, tdo_w, o, e;        // output side
	logic [BSR_LEN-1:0] pin_val, core_val, cell_val;     // cell buses
	logic [BSR_LEN-1:0] d, dout, exp_v;                  // scan data and model
	logic [1:0]         code;                            // instruction under test
	int                 n_fail, tests_run;               // counters
	logic               mq[$];                           // queue model of the shift path

	// released output shows the inverse, never a stale level
	assign tdo_w = tdo_oe ? tdo : ~tdo;

	// ============================================================
	// clock, design and scan master
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	bst_port u_bst_port (.i_core_clk(clk), .i_reset(rst), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .i_trst_n(trst_n), .i_pin_val(pin_val), .i_core_val(core_val),
		.o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_cell_val(cell_val));

	bst_jtag_master u_bst_jtag_master (.i_clk(clk), .i_tdo(tdo_w), .i_tdo_oe(tdo_oe),
		.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));

	// ============================================================
	// comparisons and closing
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_vec(input logic [BSR_LEN-1:0] got, input logic [BSR_LEN-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_vec

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	// ============================================================
	// one scan from run-test-idle back to run-test-idle
	task automatic scan(input bit ir, input int n, input logic [BSR_LEN-1:0] din);
		bit pz;                                          // pause after this shift
		u_bst_jtag_master.tick(1'b1, 1'b1, o, e);        // select-dr
		if (ir) begin
			u_bst_jtag_master.tick(1'b1, 1'b1, o, e);    // select-ir
		end
		u_bst_jtag_master.tick(1'b0, 1'b1, o, e);        // capture state
		u_bst_jtag_master.tick(1'b0, 1'b1, o, e);        // capture, enter shift
		for (int i = 0; i < n; i++) begin
			pz = code[1] && (i == n / 2 - 1);            // mid-shift pause on upper codes
			u_bst_jtag_master.tick((i == n - 1) || pz, din[i], o, e); // shift
			dout[i] = o;                                 // bit seen before this shift
			chk_bit(e, 1'b1);                            // driver on in shift
			chk_bit(o, mq.pop_front());                  // queue model, one bit
			mq.push_back(din[i]);                        // shifted-in bit queues behind
			if (pz) begin
				u_bst_jtag_master.tick(1'b0, 1'b1, o, e);  // exit1 to pause
				chk_bit(e, 1'b0);                          // driver off in exit1
				u_bst_jtag_master.tick(1'b1, 1'b1, o, e);  // pause to exit2
				u_bst_jtag_master.tick(1'b0, 1'b1, o, e);  // exit2 back to shift
			end
		end
		u_bst_jtag_master.tick(1'b1, 1'b1, o, e);        // exit1 to update
		chk_bit(e, 1'b0);                                // driver off after shift
		u_bst_jtag_master.tick(1'b0, 1'b1, o, e);        // back to idle
		repeat (4) @(posedge clk);
		#1;
	endtask : scan

	// ============================================================
	// main sequence: every instruction, then extest hold and test reset
	initial begin
		n_fail    = 0;
		tests_run = 0;
		rst       = 1'b1;
		pin_val   = '0;
		core_val  = '0;
		void'($urandom(32'h2D96));
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk_bit(tdo_oe, 1'b0);                           // idle driver off
		u_bst_jtag_master.pulse_trst();
		u_bst_jtag_master.tick(1'b1, 1'b1, o, e);        // stay in reset state
		chk_bit(e, 1'b0);
		u_bst_jtag_master.tick(1'b0, 1'b1, o, e);        // reset state to idle
		for (int c = 3; c >= 0; c--) begin
			code = 2'(c);
			for (int k = 0; k < BSR_LEN; k++) begin
				pin_val[k]  = 1'($urandom());
				core_val[k] = 1'($urandom());
				d[k]        = 1'($urandom());
			end
			mq.delete();
			mq.push_back(IR_CAPVAL[0]);                  // model: captured code, lsb first
			mq.push_back(IR_CAPVAL[1]);
			scan(1'b1, IR_LEN, {{(BSR_LEN-2){1'b0}}, code});
			chk_vec({{(BSR_LEN-2){1'b0}}, dout[1:0]}, {{(BSR_LEN-2){1'b0}}, IR_CAPVAL});
			// model: bypass delays by one from a captured zero, chain gives pins
			exp_v = (code == 2'h3) ? {d[BSR_LEN-2:0], 1'b0} : pin_val;
			mq.delete();
			if (code == IR_BYPASS) begin
				mq.push_back(1'b0);                      // model: bypass captures zero
			end else begin
				for (int k = 0; k < BSR_LEN; k++) begin
					mq.push_back(pin_val[k]);            // model: pin levels, cell 0 first
				end
			end
			scan(1'b0, BSR_LEN, d);
			chk_vec(dout, exp_v);
			chk_vec(cell_val, (code == 2'h0) ? d : core_val);
		end
		// extest holds update stage while core values move
		core_val = ~core_val;
		repeat (4) @(posedge clk);
		#1;
		chk_vec(cell_val, d);
		u_bst_jtag_master.pulse_trst();
		repeat (4) @(posedge clk);
		#1;
		chk_vec(cell_val, core_val);                     // back to bypass
		chk_bit(tdo_oe, 1'b0);
		wrap_up();
	end

	// watchdog, far past the expected length of the run
	initial begin
		#100us;
		n_fail++;
		wrap_up();
	end
endmodule : bst_port_tb
`default_nettype wire
